// >>> tx_power_defs.vh
// register map and field constants for the transmit power control bank
`ifndef TX_POWER_DEFS_VH
`define TX_POWER_DEFS_VH
`define ADDR_LOOP_CTRL 16'hbb2c
`define ADDR_XPOL_TARGET 16'hbb2d
`define ADDR_YPOL_TARGET 16'hbb2e
`define ADDR_XPOL_DRIVE 16'hbb2f
`define ADDR_YPOL_DRIVE 16'hbb30
`define ADDR_TOTAL_DRIVE 16'hbb31
`define BIT_TOTAL_LOOP 15
`define BIT_XPOL_LOOP 14
`define BIT_YPOL_LOOP 13
`define BIT_OUTPUT_OPEN 12
`define RESET_WORD 16'h0000
`define ZERO_WORD 16'h0000
`define WORD_WIDTH 16
`define RSVD_ZERO 12'h000
`define BIT_RESET 1'h0
`define KHZ_PER_MHZ 1000
`define SETTLE_TIME_MS 100
`define CLOCK_MHZ 250
`endif

// >>> tx_optical_power_control_regs.v
// transmit optical power control register bank
//
// Operation
// - bit 13 enables Y-polarisation power loop
// - bit 12 opens shutter, clear blocks output
// - X target: signed 16 bits, reset zero
// - Y target: signed 16 bits, reset zero
// - X drive writable only with X loop off
// - Y drive writable only with Y loop off
// - total drive writable only with total loop off
// - one drive step moves power at most 0.1 dB
// - drive change settles within 100 ms
// - bit 15 enables total power loop
// - bit 14 enables X-polarisation power loop
`timescale 1ns/1ps
`include "tx_power_defs.vh"
module tx_optical_power_control_regs #(
	parameter SETTLE_CYCLES = `SETTLE_TIME_MS * `CLOCK_MHZ * `KHZ_PER_MHZ
) (
	input wire clock_in,
	input wire rst_in,
	input wire [15:0] addr_in,
	input wire [15:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output wire [15:0] rdata_out,
	output wire rvalid_out,
	output wire wr_refused_out,
	output wire total_loop_en_out,
	output wire xpol_loop_en_out,
	output wire ypol_loop_en_out,
	output wire output_open_out,
	output wire [15:0] xpol_target_out,
	output wire [15:0] ypol_target_out,
	output wire [15:0] xpol_drive_out,
	output wire [15:0] ypol_drive_out,
	output wire [15:0] total_drive_out,
	output wire drive_update_out
);

	// one-hot register select codes
	localparam SEL_NONE = 6'h00;
	localparam SEL_CTRL = 6'h01;
	localparam SEL_XT = 6'h02;
	localparam SEL_YT = 6'h04;
	localparam SEL_XD = 6'h08;
	localparam SEL_YD = 6'h10;
	localparam SEL_TD = 6'h20;

	// register select, one bit per mapped word
	reg [5:0] sel;

	// control fields and their next values
	reg total_loop_en_r;
	reg total_loop_en_nxt;
	reg xpol_loop_en_r;
	reg xpol_loop_en_nxt;
	reg ypol_loop_en_r;
	reg ypol_loop_en_nxt;
	reg output_open_r;
	reg output_open_nxt;

	// power targets and their next values
	reg [15:0] xpol_target_r;
	reg [15:0] xpol_target_nxt;
	reg [15:0] ypol_target_r;
	reg [15:0] ypol_target_nxt;

	// read data and status pulses
	reg [15:0] rdata_r;
	reg [15:0] rdata_nxt;
	reg rvalid_r;
	reg wr_refused_r;
	reg drive_update_r;

	// drive words and write outcomes from the guarded cells
	wire [15:0] xpol_drive;
	wire [15:0] ypol_drive;
	wire [15:0] total_drive;
	wire xd_taken;
	wire yd_taken;
	wire td_taken;
	wire xd_refused;
	wire yd_refused;
	wire td_refused;

	// control word as read back, reserved bits zero
	wire [15:0] ctrl_word = {total_loop_en_r, xpol_loop_en_r,
		ypol_loop_en_r, output_open_r, `RSVD_ZERO};

	// address decode into a one-hot select
	always @* begin
		case (addr_in)
			`ADDR_LOOP_CTRL: sel = SEL_CTRL;
			`ADDR_XPOL_TARGET: sel = SEL_XT;
			`ADDR_YPOL_TARGET: sel = SEL_YT;
			`ADDR_XPOL_DRIVE: sel = SEL_XD;
			`ADDR_YPOL_DRIVE: sel = SEL_YD;
			`ADDR_TOTAL_DRIVE: sel = SEL_TD;
			default: sel = SEL_NONE;
		endcase
	end

	// per-register write strobes, unmapped writes go nowhere
	wire wr_ctrl = wr_in && (sel == SEL_CTRL);
	wire wr_xt = wr_in && (sel == SEL_XT);
	wire wr_yt = wr_in && (sel == SEL_YT);
	wire wr_xd = wr_in && (sel == SEL_XD);
	wire wr_yd = wr_in && (sel == SEL_YD);
	wire wr_td = wr_in && (sel == SEL_TD);

	// control fields, reserved bits dropped on write
	always @* begin
		total_loop_en_nxt = total_loop_en_r;
		xpol_loop_en_nxt = xpol_loop_en_r;
		ypol_loop_en_nxt = ypol_loop_en_r;
		output_open_nxt = output_open_r;
		if (wr_ctrl) begin
			total_loop_en_nxt = wdata_in[`BIT_TOTAL_LOOP];
			xpol_loop_en_nxt = wdata_in[`BIT_XPOL_LOOP];
			ypol_loop_en_nxt = wdata_in[`BIT_YPOL_LOOP];
			output_open_nxt = wdata_in[`BIT_OUTPUT_OPEN];
		end
	end

	// signed power targets, written whole
	always @* begin
		xpol_target_nxt = xpol_target_r;
		ypol_target_nxt = ypol_target_r;
		if (wr_xt) begin
			xpol_target_nxt = wdata_in;
		end
		if (wr_yt) begin
			ypol_target_nxt = wdata_in;
		end
	end

	// x drive word, locked while the x loop runs
	drive_word_reg #(
		.WIDTH(`WORD_WIDTH),
		.RESET_VALUE(`RESET_WORD)
	) x_drive (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.wr_in(wr_xd),
		.lock_in(xpol_loop_en_r),
		.data_in(wdata_in),
		.word_out(xpol_drive),
		.taken_out(xd_taken),
		.refused_out(xd_refused)
	);

	// y drive word, locked while the y loop runs
	drive_word_reg #(
		.WIDTH(`WORD_WIDTH),
		.RESET_VALUE(`RESET_WORD)
	) y_drive (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.wr_in(wr_yd),
		.lock_in(ypol_loop_en_r),
		.data_in(wdata_in),
		.word_out(ypol_drive),
		.taken_out(yd_taken),
		.refused_out(yd_refused)
	);

	// total drive word, locked while the total loop runs
	drive_word_reg #(
		.WIDTH(`WORD_WIDTH),
		.RESET_VALUE(`RESET_WORD)
	) total_drive_cell (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.wr_in(wr_td),
		.lock_in(total_loop_en_r),
		.data_in(wdata_in),
		.word_out(total_drive),
		.taken_out(td_taken),
		.refused_out(td_refused)
	);

	// read mux, old value on a same-cycle write, unmapped reads zero
	always @* begin
		rdata_nxt = rdata_r;
		if (rd_in) begin
			case (sel)
				SEL_CTRL: rdata_nxt = ctrl_word;
				SEL_XT: rdata_nxt = xpol_target_r;
				SEL_YT: rdata_nxt = ypol_target_r;
				SEL_XD: rdata_nxt = xpol_drive;
				SEL_YD: rdata_nxt = ypol_drive;
				SEL_TD: rdata_nxt = total_drive;
				default: rdata_nxt = `ZERO_WORD;
			endcase
		end
	end

	// bank flip-flops, synchronous reset
	always @(posedge clock_in) begin
		if (rst_in) begin
			total_loop_en_r <= `BIT_RESET;
			xpol_loop_en_r <= `BIT_RESET;
			ypol_loop_en_r <= `BIT_RESET;
			output_open_r <= `BIT_RESET;
			xpol_target_r <= `RESET_WORD;
			ypol_target_r <= `RESET_WORD;
			rdata_r <= `ZERO_WORD;
			rvalid_r <= `BIT_RESET;
			wr_refused_r <= `BIT_RESET;
			drive_update_r <= `BIT_RESET;
		end else begin
			total_loop_en_r <= total_loop_en_nxt;
			xpol_loop_en_r <= xpol_loop_en_nxt;
			ypol_loop_en_r <= ypol_loop_en_nxt;
			output_open_r <= output_open_nxt;
			xpol_target_r <= xpol_target_nxt;
			ypol_target_r <= ypol_target_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rd_in;
			wr_refused_r <= xd_refused || yd_refused || td_refused;
			drive_update_r <= xd_taken || yd_taken || td_taken;
		end
	end

	// outputs straight from the flip-flops
	assign rdata_out = rdata_r;
	assign rvalid_out = rvalid_r;
	assign wr_refused_out = wr_refused_r;
	assign total_loop_en_out = total_loop_en_r;
	assign xpol_loop_en_out = xpol_loop_en_r;
	assign ypol_loop_en_out = ypol_loop_en_r;
	assign output_open_out = output_open_r;
	assign xpol_target_out = xpol_target_r;
	assign ypol_target_out = ypol_target_r;
	assign xpol_drive_out = xpol_drive; // one lsb per code
	assign ypol_drive_out = ypol_drive;
	assign total_drive_out = total_drive;
	assign drive_update_out = drive_update_r;

endmodule

// one drive word, held against writes while its loop runs
module drive_word_reg #(
	parameter WIDTH = `WORD_WIDTH,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire clock_in,
	input wire rst_in,
	input wire wr_in,
	input wire lock_in,
	input wire [WIDTH-1:0] data_in,
	output wire [WIDTH-1:0] word_out,
	output wire taken_out,
	output wire refused_out
);

	// stored word and its next value
	reg [WIDTH-1:0] word_r;
	reg [WIDTH-1:0] word_nxt;

	// a write lands only while the lock is low
	assign taken_out = wr_in && !lock_in;
	assign refused_out = wr_in && lock_in;

	// next value, unchanged unless a write lands
	always @* begin
		word_nxt = word_r;
		if (taken_out) begin
			word_nxt = data_in;
		end
	end

	// word flip-flops, synchronous reset
	always @(posedge clock_in) begin
		if (rst_in) begin
			word_r <= RESET_VALUE;
		end else begin
			word_r <= word_nxt;
		end
	end

	// drive code leaves unchanged
	assign word_out = word_r;

endmodule

// >>> tx_host_model.sv
// host side model driving the register strobes
`timescale 1ns/1ps
module tx_host_model(input wire clock_in,output reg [15:0] addr_out,
output reg [15:0] wdata_out,output reg wr_out,output reg rd_out);
initial {addr_out,wdata_out,wr_out,rd_out}=0;
// one access, then address and data flipped and strobes dropped so stale values never pass
task acc(logic w,logic [15:0] a,d);
@(negedge clock_in) {addr_out,wdata_out,wr_out,rd_out}={a,d,w,!w};
@(negedge clock_in) {addr_out,wdata_out,wr_out,rd_out}={~a,~d,2'b0};
endtask
endmodule

// >>> tx_power_sva.sv
// assertions on the power control bank
`timescale 1ns/1ps
module tx_power_sva(input wire clock_in,rst_in,wr_in,rd_in,wr_refused_out,
input wire total_loop_en_out,xpol_loop_en_out,ypol_loop_en_out,
input wire output_open_out,input wire [15:0] addr_in,wdata_in,
input wire [15:0] rdata_out,xpol_drive_out,ypol_drive_out,total_drive_out,
input wire [15:0] ypol_target_out,input wire drive_update_out);
default clocking @(posedge clock_in); endclocking
default disable iff (rst_in);
sequence cw; wr_in&&addr_in==16'hbb2c; endsequence
sequence xw; wr_in&&addr_in==16'hbb2f; endsequence
sequence yw; wr_in&&addr_in==16'hbb30; endsequence
sequence tw; wr_in&&addr_in==16'hbb31; endsequence
a_total_loop: assert property(cw|=>total_loop_en_out==$past(wdata_in[15]))
else $error("bit15");
a_xpol_loop: assert property(cw|=>xpol_loop_en_out==$past(wdata_in[14]))
else $error("bit14");
a_ypol_loop: assert property(cw|=>ypol_loop_en_out==$past(wdata_in[13]))
else $error("bit13");
a_shutter_bit: assert property(cw|=>output_open_out==$past(wdata_in[12]))
else $error("bit12");
a_x_refused: assert property((xw and xpol_loop_en_out)|=>
wr_refused_out&&$stable(xpol_drive_out)) else $error("x refuse");
a_x_taken: assert property((xw and !xpol_loop_en_out)|=>
xpol_drive_out==$past(wdata_in)) else $error("x take");
a_ctrl_read: assert property(rd_in&&addr_in==16'hbb2c|=>rdata_out[11:0]==0)
else $error("reserved");
a_drive_read: assert property(rd_in&&addr_in==16'hbb2f|=>
rdata_out==$past(xpol_drive_out)) else $error("x read");
a_y_refused: assert property((yw and ypol_loop_en_out)|=>
wr_refused_out&&$stable(ypol_drive_out)) else $error("y refuse");
a_t_refused: assert property((tw and total_loop_en_out)|=>
wr_refused_out&&$stable(total_drive_out)) else $error("t refuse");
a_update_pulse: assert property((xw and !xpol_loop_en_out)|=>
drive_update_out) else $error("update");
a_y_target: assert property(wr_in&&addr_in==16'hbb2e|=>
ypol_target_out==$past(wdata_in)) else $error("y target");
endmodule
bind tx_optical_power_control_regs tx_power_sva chk(.*);

// >>> tx_optical_power_control_regs_tb_top.sv
// bench for the power control bank
`timescale 1ns/1ps
module tx_optical_power_control_regs_tb_top;
reg clock_in=0,rst_in=1;
wire [15:0] addr_in,wdata_in,rdata_out,xpol_target_out,ypol_target_out;
wire [15:0] xpol_drive_out,ypol_drive_out,total_drive_out;
wire wr_in,rd_in,rvalid_out,wr_refused_out,total_loop_en_out;
wire xpol_loop_en_out,ypol_loop_en_out,output_open_out,drive_update_out;
int fail_count=0,n_tests=0;
always #2 clock_in=~clock_in;
tx_host_model H(.clock_in,.addr_out(addr_in),.wdata_out(wdata_in),
.wr_out(wr_in),.rd_out(rd_in));
tx_optical_power_control_regs DUT(.*);
task chk(string s,logic [15:0] g,e);
n_tests++;
if(g!==e) begin fail_count++;$display("mismatch %s %h %h",s,e,g);end
endtask
task wrap_up;
$display("checks %0d errors %0d",n_tests,fail_count);
if(fail_count==0&&n_tests>0) $display("Run complete: PASS");
else $display("Run complete: FAIL");
$finish;
endtask
task t_reset;
H.acc(0,16'hbb2c,0);chk("ctl",rdata_out,0);
chk("rv",rvalid_out,1);
chk("zero",xpol_target_out|ypol_target_out|xpol_drive_out,0);
endtask
task t_ctrl;
H.acc(1,16'hbb2c,16'hffff);chk("open",output_open_out,1);
chk("tl",total_loop_en_out,1);
chk("xl",xpol_loop_en_out,1);
chk("yl",ypol_loop_en_out,1);
H.acc(0,16'hbb2c,0);chk("ctl",rdata_out,16'hf000);
endtask
task t_drive;
H.acc(1,16'hbb2f,16'h1234);chk("ref",wr_refused_out,1);
chk("xd",xpol_drive_out,0);
chk("nup",drive_update_out,0);
chk("nrv",rvalid_out,0);
H.acc(1,16'hbb30,16'h5555);chk("yref",wr_refused_out,1);
chk("ydl",ypol_drive_out,0);
H.acc(1,16'hbb31,16'h5555);chk("tref",wr_refused_out,1);
chk("tdl",total_drive_out,0);
H.acc(1,16'hbb2c,0);H.acc(1,16'hbb30,16'h8001);
chk("yd",ypol_drive_out,16'h8001);
chk("up",drive_update_out,1);
chk("ok",wr_refused_out,0);
H.acc(1,16'hbb31,16'hffff);chk("td",total_drive_out,16'hffff);
H.acc(1,16'hbb2f,1);H.acc(1,16'hbb2d,16'h8000);
H.acc(1,16'hbb2e,16'h7fff);chk("yt",ypol_target_out,16'h7fff);
H.acc(0,16'hbb2f,0);chk("xr",rdata_out,1);
chk("xt",xpol_target_out,16'h8000);
endtask
initial begin
repeat(5) @(negedge clock_in);rst_in=0;
t_reset;t_ctrl;t_drive;wrap_up;
end
initial begin #40000;fail_count++;wrap_up;end
endmodule
